// >>> src/bcc_defs.vh
// Functional notes
// RQ1 - Charger sits in Off whenever its supply is absent.
// RQ2 - Supply present and battery below 2.9 V selects trickle charge.
// RQ3 - Battery above 2.9 V, below float, selects constant-current fast charge.
// RQ4 - At float voltage switch to constant voltage, trimming current to hold float.
// RQ5 - Charging stops when battery reaches the 4.2 V termination level.
// RQ6 - Fully charged battery enters standby with no charge current.
// RQ7 - Codes 1..15 pick current evenly spaced from 40 mA to 135 mA.
// RQ8 - Codes outside 0..15 leave the present charge current unchanged.
// RQ9 - Code zero means no change; default zero gives nominal 40 mA.
// RQ10 - Supply present and not full: charger runs and indicator LED lights.
// RQ11 - Until firmware runs, LED pulses at low duty cycle.
// RQ12 - Charger supply presence is detected and readable by firmware.
// RQ13 - Three programmable mV thresholds: warning start, regulator off, warning cease.
// RQ14 - Low-battery warning drives a configured general-purpose pin while it holds.
// RQ15 - Firmware should set turn-off threshold to keep battery above 2.8 V.
// RQ16 - Transitions are evaluated on each new battery sample, registered next edge.
// RQ17 - From standby, resume charging when battery drops below float with supply present.
`ifndef BCC_DEFS_VH
`define BCC_DEFS_VH
`define BCC_REG_CHG_LEVEL 12'h39b
`define BCC_REG_CTRL 12'h3a0
`define BCC_REG_STATUS 12'h3a1
`define BCC_REG_WARN_ON 12'h3a2
`define BCC_REG_REG_OFF 12'h3a3
`define BCC_REG_WARN_OFF 12'h3a4
`define BCC_REG_FLOAT 12'h3a5
`define BCC_REG_TERM 12'h3a6
`define BCC_REG_IRQ_STAT 12'h3a7
`define BCC_REG_IRQ_EN 12'h3a8
`define BCC_REG_IRQ_CLR 12'h3a9
`define BCC_REG_CUR_MA 12'h3aa
`define BCC_CHG_LEVEL_RST 16'h0000
`define BCC_TRICKLE_MV 16'h0b54
`define BCC_FLOAT_MV_RST 16'h1036
`define BCC_TERM_MV_RST 16'h1068
`define BCC_WARN_ON_RST 16'h0d48
`define BCC_REG_OFF_RST 16'h0ce4
`define BCC_WARN_OFF_RST 16'h0fa0
`define BCC_CUR_BASE_MA 8'h28
`define BCC_CUR_MAX_MA 8'h87
`define BCC_CUR_STEP_NUM 16'h005f
`define BCC_CUR_STEP_DEN 16'h000e
`define BCC_LED_PERIOD 16'h4e20
`define BCC_LED_ON 16'h07d0
`define BCC_CTRL_FW_RUN 0
`define BCC_CTRL_PIN_LO 1
`define BCC_CTRL_PIN_HI 4
`define BCC_IRQ_W 4
`endif

// >>> src/bcc_charge_control.v
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.vh"
module bcc_charge_control #(
    parameter ADDR_W = 12,
    parameter NUM_PIO = 16
) (
    input wire I_MCLK,
    input wire I_RESETN,
    input wire [ADDR_W-1:0] I_ADDR,
    input wire [15:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output reg [15:0] O_RDATA,
    input wire I_CHARGER_SUPPLY_IN,
    input wire [15:0] I_BATTERY_TERMINAL_MV,
    input wire I_SAMPLE_VALID,
    output reg O_CHARGE_EN,
    output reg O_CV_MODE,
    output reg [7:0] O_CHARGE_MA,
    output reg O_CHARGE_INDICATOR_LED,
    output reg O_REGULATOR_OFF,
    output reg [NUM_PIO-1:0] O_LOW_BATTERY_INDICATOR_PIN,
    output reg [NUM_PIO-1:0] O_LOW_BATTERY_INDICATOR_PIN_OE_N,
    output wire O_IRQ
);

// ----------------------------------------
// States and events
// ----------------------------------------
localparam ST_OFF = 5'h01;
localparam ST_TRICKLE = 5'h02;
localparam ST_CC = 5'h04;
localparam ST_CV = 5'h08;
localparam ST_STBY = 5'h10;

reg [4:0] state_r;
reg [4:0] state_nxt;
reg [15:0] level_r;
reg [7:0] cur_ma_r;
reg [15:0] ctrl_r;
reg [15:0] warn_on_r;
reg [15:0] reg_off_r;
reg [15:0] warn_off_r;
reg [15:0] float_r;
reg [15:0] term_r;
reg [15:0] bat_r;
reg warn_r;
reg regoff_r;
reg supply_d_r;
reg [15:0] led_cnt_r;
reg [`BCC_IRQ_W-1:0] irq_stat_r;
reg [`BCC_IRQ_W-1:0] irq_en_r;
reg [`BCC_IRQ_W-1:0] irq_clr;
wire [`BCC_IRQ_W-1:0] irq_evt;
wire [3:0] pin_sel;
wire charging;
reg warn_nxt;
reg [8:0] step_ma;
wire [15:0] code_m1;
wire [15:0] cur_calc;
wire evt_supply;
wire evt_stby;
wire evt_warn;
wire evt_regoff;
wire [15:0] status_word;

assign pin_sel = ctrl_r[`BCC_CTRL_PIN_HI:`BCC_CTRL_PIN_LO];
assign charging = state_r[1] | state_r[2] | state_r[3];

// ----------------------------------------
// Charger state machine
// ----------------------------------------
always @* begin
    state_nxt = state_r;
    // Supply loss overrides any sample
    if (!I_CHARGER_SUPPLY_IN) begin
        state_nxt = ST_OFF; // RQ1
    end else if (I_SAMPLE_VALID) begin // RQ16
        case (state_r)
            ST_OFF, ST_TRICKLE, ST_CC: begin
                if (I_BATTERY_TERMINAL_MV < `BCC_TRICKLE_MV) begin
                    state_nxt = ST_TRICKLE; // RQ2
                end else if (I_BATTERY_TERMINAL_MV < float_r) begin
                    state_nxt = ST_CC; // RQ3
                end else begin
                    state_nxt = ST_CV; // RQ4
                end
            end
            ST_CV: begin
                if (I_BATTERY_TERMINAL_MV >= term_r) begin
                    state_nxt = ST_STBY; // RQ5 RQ6
                end else if (I_BATTERY_TERMINAL_MV < `BCC_TRICKLE_MV) begin
                    state_nxt = ST_TRICKLE;
                end
            end
            ST_STBY: begin
                if (I_BATTERY_TERMINAL_MV < float_r) begin
                    state_nxt = (I_BATTERY_TERMINAL_MV < `BCC_TRICKLE_MV) ? ST_TRICKLE : ST_CC; // RQ17
                end
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
    end
end

// Trickle runs at a quarter of the base current
always @* begin
    step_ma = 9'h000;
    if (state_r == ST_TRICKLE) begin
        step_ma = {1'b0, `BCC_CUR_BASE_MA} >> 2;
    end else if (state_r == ST_CC || state_r == ST_CV) begin
        step_ma = {1'b0, cur_ma_r};
    end
end

// ----------------------------------------
// Charge current decode
// ----------------------------------------
// Widened to 16 bits so the product of code and step cannot wrap
assign code_m1 = I_WDATA - 16'h0001;
assign cur_calc = {8'h00, `BCC_CUR_BASE_MA} + (code_m1 * `BCC_CUR_STEP_NUM) / `BCC_CUR_STEP_DEN; // RQ7

// ----------------------------------------
// Low-battery protection
// ----------------------------------------
always @* begin
    warn_nxt = warn_r;
    // No warning before the first sample has arrived
    if (bat_r <= warn_on_r && bat_r != 16'h0000) begin
        warn_nxt = 1'b1; // RQ13
    end else if (bat_r >= warn_off_r) begin
        warn_nxt = 1'b0; // RQ13
    end
end

// ----------------------------------------
// Interrupt events
// ----------------------------------------
assign evt_supply = I_CHARGER_SUPPLY_IN ^ supply_d_r;
assign evt_stby = (state_nxt == ST_STBY) && (state_r != ST_STBY);
assign evt_warn = warn_nxt & ~warn_r;
// Fires once, on the first sample at or below the turn-off level
assign evt_regoff = !regoff_r && (bat_r <= reg_off_r) && (bat_r != 16'h0000);
assign irq_evt = {evt_regoff, evt_warn, evt_stby, evt_supply};

// ----------------------------------------
// Status word
// ----------------------------------------
assign status_word = {7'h00,
                      regoff_r,
                      warn_r,
                      I_CHARGER_SUPPLY_IN, // RQ12
                      1'b0,
                      state_r};

// ----------------------------------------
// Registers and outputs
// ----------------------------------------

always @(posedge I_MCLK) begin
    if (!I_RESETN) begin
        state_r <= ST_OFF;
        level_r <= `BCC_CHG_LEVEL_RST;
        cur_ma_r <= `BCC_CUR_BASE_MA;
        ctrl_r <= 16'h0000;
        warn_on_r <= `BCC_WARN_ON_RST;
        reg_off_r <= `BCC_REG_OFF_RST;
        warn_off_r <= `BCC_WARN_OFF_RST;
        float_r <= `BCC_FLOAT_MV_RST;
        term_r <= `BCC_TERM_MV_RST;
        bat_r <= 16'h0000;
        warn_r <= 1'b0;
        regoff_r <= 1'b0;
        supply_d_r <= 1'b0;
        irq_stat_r <= {`BCC_IRQ_W{1'b0}};
        irq_en_r <= {`BCC_IRQ_W{1'b0}};
        O_RDATA <= 16'h0000;
        O_CHARGE_EN <= 1'b0;
        O_CV_MODE <= 1'b0;
        O_CHARGE_MA <= 8'h00;
        O_CHARGE_INDICATOR_LED <= 1'b0;
        O_REGULATOR_OFF <= 1'b0;
        O_LOW_BATTERY_INDICATOR_PIN <= {NUM_PIO{1'b0}};
        O_LOW_BATTERY_INDICATOR_PIN_OE_N <= {NUM_PIO{1'b1}};
    end else begin
        state_r <= state_nxt; // RQ16
        supply_d_r <= I_CHARGER_SUPPLY_IN;
        if (I_SAMPLE_VALID) begin
            bat_r <= I_BATTERY_TERMINAL_MV;
        end
        warn_r <= warn_nxt;
        // Sticky until reset: regulators stay off once tripped
        if (bat_r <= reg_off_r && bat_r != 16'h0000) begin
            regoff_r <= 1'b1; // RQ13
        end
        O_REGULATOR_OFF <= regoff_r;
        // Only the selected pin is driven, the others stay released
        // RQ14
        O_LOW_BATTERY_INDICATOR_PIN <= {NUM_PIO{1'b0}};
        O_LOW_BATTERY_INDICATOR_PIN_OE_N <= {NUM_PIO{1'b1}};
        O_LOW_BATTERY_INDICATOR_PIN[pin_sel] <= warn_r;
        O_LOW_BATTERY_INDICATOR_PIN_OE_N[pin_sel] <= 1'b0;
        // ----------------------------------------
        // Charge outputs
        // ----------------------------------------
        // Charge outputs follow the registered state
        O_CHARGE_EN <= charging; // RQ6 RQ10
        O_CV_MODE <= (state_r == ST_CV); // RQ4
        O_CHARGE_MA <= step_ma[7:0];
        // RQ10 RQ11
        if (!charging) begin
            O_CHARGE_INDICATOR_LED <= 1'b0;
        end else if (ctrl_r[`BCC_CTRL_FW_RUN]) begin
            O_CHARGE_INDICATOR_LED <= 1'b1;
        end else begin
            O_CHARGE_INDICATOR_LED <= (led_cnt_r < `BCC_LED_ON);
        end
        // Events set, set wins over clear
        irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
        // ----------------------------------------
        // Register write path
        // ----------------------------------------
        // Register writes
        if (I_WR) begin
            case (I_ADDR)
                `BCC_REG_CHG_LEVEL: begin
                    // Codes above 15 are dropped entirely
                    // A zero is stored for readback but keeps the current
                    if (I_WDATA <= 16'h000f) begin // RQ8
                        level_r <= I_WDATA;
                        if (I_WDATA != 16'h0000) begin // RQ9
                            // RQ7: 40 + (code-1)*95/14 mA, rounded down
                            cur_ma_r <= cur_calc[7:0];
                        end
                    end
                end
                `BCC_REG_CTRL: ctrl_r <= I_WDATA;
                `BCC_REG_WARN_ON: warn_on_r <= I_WDATA;
                `BCC_REG_REG_OFF: reg_off_r <= I_WDATA;
                `BCC_REG_WARN_OFF: warn_off_r <= I_WDATA;
                `BCC_REG_FLOAT: float_r <= I_WDATA;
                `BCC_REG_TERM: term_r <= I_WDATA;
                `BCC_REG_IRQ_EN: irq_en_r <= I_WDATA[`BCC_IRQ_W-1:0];
                default: begin
                end
            endcase
        end
        // ----------------------------------------
        // Register read path
        // ----------------------------------------
        // Register reads, answered one cycle later
        O_RDATA <= 16'h0000;
        if (I_RD) begin
            case (I_ADDR)
                `BCC_REG_CHG_LEVEL: O_RDATA <= level_r;
                `BCC_REG_CTRL: O_RDATA <= ctrl_r;
                // RQ12
                `BCC_REG_STATUS: O_RDATA <= status_word;
                `BCC_REG_WARN_ON: O_RDATA <= warn_on_r;
                `BCC_REG_REG_OFF: O_RDATA <= reg_off_r;
                `BCC_REG_WARN_OFF: O_RDATA <= warn_off_r;
                `BCC_REG_FLOAT: O_RDATA <= float_r;
                `BCC_REG_TERM: O_RDATA <= term_r;
                `BCC_REG_IRQ_STAT: O_RDATA <= {{(16-`BCC_IRQ_W){1'b0}}, irq_stat_r};
                `BCC_REG_IRQ_EN: O_RDATA <= {{(16-`BCC_IRQ_W){1'b0}}, irq_en_r};
                `BCC_REG_CUR_MA: O_RDATA <= {8'h00, cur_ma_r};
                default: O_RDATA <= 16'h0000;
            endcase
        end
    end
end

// ----------------------------------------
// Indicator pulse timer
// ----------------------------------------
// Free-running, so the pulse phase does not depend on when charging starts
always @(posedge I_MCLK) begin
    if (!I_RESETN) begin
        led_cnt_r <= 16'h0000;
    end else if (led_cnt_r >= `BCC_LED_PERIOD - 16'h0001) begin
        led_cnt_r <= 16'h0000; // RQ11
    end else begin
        led_cnt_r <= led_cnt_r + 16'h0001;
    end
end

// ----------------------------------------
// Interrupt clear and request
// ----------------------------------------
always @* begin
    irq_clr = {`BCC_IRQ_W{1'b0}};
    if (I_WR && I_ADDR == `BCC_REG_IRQ_CLR) begin
        irq_clr = I_WDATA[`BCC_IRQ_W-1:0];
    end
end

// Level output, high while any enabled status bit is set
assign O_IRQ = |(irq_stat_r & irq_en_r);

endmodule // bcc_charge_control
`default_nettype wire

// >>> tb/bcc_cell_model.sv
`timescale 1ns/10ps
`default_nettype none
module bcc_cell_model (
    input wire logic i_clk,
    input wire logic i_take,
    input wire logic [15:0] i_mv,
    output logic o_valid,
    output logic [15:0] o_mv
);
    logic v_r = 1'b0;
    logic [15:0] mv_r = 16'h0;
    // Voltage bus shows junk outside the one-cycle sample
    assign o_valid = v_r;
    assign o_mv = v_r ? mv_r : ~mv_r;
    always @(posedge i_clk) begin
        v_r <= i_take;
        mv_r <= i_take ? i_mv : mv_r;
    end
endmodule // bcc_cell_model
`default_nettype wire

// >>> tb/bcc_chk.sv
`timescale 1ns/10ps
`default_nettype none
module bcc_chk #(
    parameter NUM_PIO = 16
) (
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    input wire logic I_CHARGER_SUPPLY_IN,
    input wire logic [15:0] I_BATTERY_TERMINAL_MV,
    input wire logic I_SAMPLE_VALID,
    input wire logic O_CHARGE_EN,
    input wire logic O_CV_MODE,
    input wire logic [7:0] O_CHARGE_MA,
    input wire logic O_CHARGE_INDICATOR_LED,
    input wire logic O_REGULATOR_OFF,
    input wire logic [NUM_PIO-1:0] O_LOW_BATTERY_INDICATOR_PIN,
    input wire logic [NUM_PIO-1:0] O_LOW_BATTERY_INDICATOR_PIN_OE_N
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESETN);
    sequence s_low;
        I_SAMPLE_VALID && I_CHARGER_SUPPLY_IN && I_BATTERY_TERMINAL_MV < 16'h0b54;
    endsequence
    sequence s_mid;
        I_SAMPLE_VALID && I_CHARGER_SUPPLY_IN && O_CHARGE_EN && !O_CV_MODE
            && I_BATTERY_TERMINAL_MV > 16'h0b54 && I_BATTERY_TERMINAL_MV < 16'h1036;
    endsequence
    AST_OFF: assert property (I_SAMPLE_VALID && !I_CHARGER_SUPPLY_IN |-> ##2 !O_CHARGE_EN)
        else $error("charging without supply");
    AST_TRICKLE: assert property (s_low |-> ##2 O_CHARGE_EN && O_CHARGE_MA == 8'h0a)
        else $error("no trickle");
    AST_FAST: assert property (s_mid |-> ##2 O_CHARGE_EN && !O_CV_MODE)
        else $error("no fast charge");
    AST_CV: assert property (O_CV_MODE |-> O_CHARGE_EN)
        else $error("cv while idle");
    AST_IDLE: assert property (!O_CHARGE_EN |-> O_CHARGE_MA == 8'h0)
        else $error("current while idle");
    AST_LED: assert property (O_CHARGE_INDICATOR_LED |-> O_CHARGE_EN || $past(O_CHARGE_EN))
        else $error("led while idle");
    AST_PIN: assert property ((O_LOW_BATTERY_INDICATOR_PIN & O_LOW_BATTERY_INDICATOR_PIN_OE_N) == '0)
        else $error("pin set but not driven");
    AST_ROFF: assert property (O_REGULATOR_OFF |=> O_REGULATOR_OFF)
        else $error("regulator off lost");
endmodule // bcc_chk
bind bcc_charge_control bcc_chk #(.NUM_PIO(NUM_PIO)) chk_u (
    .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_CHARGER_SUPPLY_IN(I_CHARGER_SUPPLY_IN),
    .I_BATTERY_TERMINAL_MV(I_BATTERY_TERMINAL_MV), .I_SAMPLE_VALID(I_SAMPLE_VALID),
    .O_CHARGE_EN(O_CHARGE_EN), .O_CV_MODE(O_CV_MODE), .O_CHARGE_MA(O_CHARGE_MA),
    .O_CHARGE_INDICATOR_LED(O_CHARGE_INDICATOR_LED), .O_REGULATOR_OFF(O_REGULATOR_OFF),
    .O_LOW_BATTERY_INDICATOR_PIN(O_LOW_BATTERY_INDICATOR_PIN),
    .O_LOW_BATTERY_INDICATOR_PIN_OE_N(O_LOW_BATTERY_INDICATOR_PIN_OE_N));
`default_nettype wire

// >>> tb/tb_battery_charge_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_battery_charge_control;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, sup = 1'b0, take = 1'b0;
    logic [11:0] addr = 12'h0;
    logic [15:0] wd = 16'h0, mv = 16'h0;
    logic [15:0] bat, rdat, pin, oen;
    logic [15:0] exp_q[$];
    logic vld, en, cv, led, roff, irq;
    logic [7:0] ma;
    logic [31:0] lf = 32'h9dff;
    int fail_count = 0, n_compared = 0, k = 0;
    always #25 clk = ~clk;
    bcc_cell_model cell_u (.i_clk(clk), .i_take(take), .i_mv(mv), .o_valid(vld), .o_mv(bat));
    bcc_charge_control dut_u (
        .I_MCLK(clk), .I_RESETN(rstn), .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdat),
        .I_CHARGER_SUPPLY_IN(sup), .I_BATTERY_TERMINAL_MV(bat), .I_SAMPLE_VALID(vld), .O_CHARGE_EN(en),
        .O_CV_MODE(cv), .O_CHARGE_MA(ma), .O_CHARGE_INDICATOR_LED(led), .O_REGULATOR_OFF(roff),
        .O_LOW_BATTERY_INDICATOR_PIN(pin), .O_LOW_BATTERY_INDICATOR_PIN_OE_N(oen), .O_IRQ(irq));
    task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wreg(logic [11:0] a, logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(logic [11:0] a, logic [15:0] e);
        @(posedge clk);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // One battery sample, then wait until the charge outputs have settled
    task automatic smp(logic [15:0] v);
        @(posedge clk);
        mv <= v;
        take <= 1'b1;
        @(posedge clk);
        take <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    always @(posedge clk) begin
        rd_q <= rd;
        if (rd_q) begin
            chk("rdata", exp_q.pop_front(), rdat);
        end
    end
    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rreg(12'h3aa, 16'd40);
        rreg(12'h3ff, 16'h0);
        for (int c = 1; c < 16; c++) begin
            wreg(12'h39b, c[15:0]);
            rreg(12'h39b, c[15:0]);
            rreg(12'h3aa, 16'(40 + (c - 1) * 95 / 14));
        end
        wreg(12'h39b, 16'h0);
        rreg(12'h3aa, 16'd135);
        lf = lfsr(lf);
        wreg(12'h39b, lf[15:0] | 16'h0010);
        rreg(12'h3aa, 16'd135);
        wreg(12'h3a3, 16'd2800);
        wreg(12'h3a0, 16'h000a);
        wreg(12'h3a8, 16'h0002);
        sup <= 1'b1;
        smp(16'd2850);
        chk("ma", 16'd10, 16'(ma));
        chk("pin", 16'h0020, pin);
        chk("irq", 16'h0, 16'(irq));
        repeat (20000) begin
            @(negedge clk);
            k += led;
        end
        chk("duty", 16'd2000, k[15:0]);
        wreg(12'h3a0, 16'h000b);
        rreg(12'h3a1, 16'h00c2);
        @(negedge clk);
        chk("led", 16'h1, 16'(led));
        smp(16'd3600);
        chk("ma", 16'd135, 16'(ma));
        rreg(12'h3a1, 16'h00c4);
        smp(16'd4160);
        chk("cv", 16'h1, 16'(cv));
        rreg(12'h3a1, 16'h0048);
        smp(16'd4200);
        chk("ma", 16'h0, 16'(ma));
        chk("irq", 16'h1, 16'(irq));
        rreg(12'h3a1, 16'h0050);
        wreg(12'h3a9, 16'h000f);
        rreg(12'h3a7, 16'h0);
        @(negedge clk);
        chk("irq", 16'h0, 16'(irq));
        smp(16'd4100);
        rreg(12'h3a1, 16'h0044);
        @(posedge clk);
        sup <= 1'b0;
        smp(16'd4100);
        chk("en", 16'h0, 16'(en));
        rreg(12'h3a1, 16'h0001);
        smp(16'd2700);
        chk("roff", 16'h1, 16'(roff));
        rreg(12'h3a7, 16'h000d);
        rreg(12'h3a1, 16'h0181);
        repeat (2) @(posedge clk);
        final_report();
    end
endmodule // tb_battery_charge_control
`default_nettype wire
